// ---- logic/mslc_pkg.sv ----
// Package of constants for the motion sensor link core.
package mslc_pkg;
	// Bit of the motion flags byte that marks direction info.
	localparam int         MSLC_DIR_AVAIL_BIT = 7;
	// Control vector, high and low halves joined.
	localparam logic [127:0] MSLC_KEY_CTRL_VECTOR = {64'h48215f000341328a, 64'h00684d00cb21701d};
	// Line levels of the frame delimiters.
	localparam logic       MSLC_START_LEVEL = 1'b0;
	localparam logic       MSLC_STOP_LEVEL  = 1'b1;
	localparam logic       MSLC_IDLE_LEVEL  = 1'b1;
	// Frame has eleven bit slots: start, eight data, parity, stop.
	localparam int         MSLC_FRAME_BITS  = 11;
	// Default bit period in core clocks.
	localparam int         MSLC_BIT_CLKS    = 16;
	// Parity sense: 0 gives even parity.
	localparam logic       MSLC_PARITY_ODD  = 1'b0;
	// Transmit state machine.
	typedef enum logic [1:0] {
		MSLC_IDLE,
		MSLC_SHIFT
	} mslc_state_t;
endpackage

// ---- logic/mslc_key_xor.sv ----
// Combinational derivation of the identification key.
module mslc_key_xor
	import mslc_pkg::*;
(
	input  wire logic [127:0] master_key,
	output logic      [127:0] ident_key
);
	// Key is never registered here, so it lives only on wires while used.
	assign ident_key = master_key ^ MSLC_KEY_CTRL_VECTOR;
endmodule

// ---- logic/mslc_core.sv ----
// Motion sensor side of the serial link: byte framer, supply gate, watchdog restart.
module mslc_core
	import mslc_pkg::*;
#(
	parameter int BIT_CLKS = MSLC_BIT_CLKS
)
(
	input  wire logic         core_clk,
	input  wire logic         sys_rst,
	input  wire logic         watchdog_in,
	input  wire logic         supply_ok,
	input  wire logic         tx_valid,
	input  wire logic [7:0]   tx_data,
	output logic              tx_ready,
	output logic              txd_out,
	input  wire logic [6:0]   motion_flags_low,
	input  wire logic         dir_info_avail,
	output logic [7:0]        motion_flags_byte,
	input  wire logic [127:0] master_key,
	input  wire logic         init_active,
	output logic [127:0]      ident_key
);
	//////////////////////////////////////////////////////////////////////
	// Identification key and motion flags.
	//////////////////////////////////////////////////////////////////////

	logic [127:0] key_raw;                // Derived key before gating.

	// The key only appears while initialisation is in progress.
	mslc_key_xor u_key (
		.master_key (master_key),
		.ident_key  (key_raw)
	);
	assign ident_key = init_active ? key_raw : '0;

	logic [7:0] flags_next;               // Next motion flags byte.
	logic [7:0] flags_reg;                // Registered motion flags byte.

	// Assemble the flags byte with the direction bit in position 7.
	always_comb begin
		flags_next = {dir_info_avail, motion_flags_low};
	end

	// Register the flags so the output comes from a flip-flop.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			flags_reg <= 8'h00;
		end else begin
			flags_reg <= flags_next;
		end
	end
	assign motion_flags_byte = flags_reg;

	//////////////////////////////////////////////////////////////////////
	// Watchdog edge detection.
	//////////////////////////////////////////////////////////////////////

	logic wd_prev_reg;                    // Watchdog line one clock ago.
	logic wd_prev_next;                   // Next value of the above.
	logic wd_pulse;                       // Rising edge of the watchdog line.

	// Track the line; an edge rather than a level restarts us, so a stuck line
	// does not hold the sensor in restart forever.
	always_comb begin
		wd_prev_next = watchdog_in;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wd_prev_reg <= 1'b0;
		end else begin
			wd_prev_reg <= wd_prev_next;
		end
	end
	assign wd_pulse = watchdog_in & ~wd_prev_reg;

	//////////////////////////////////////////////////////////////////////
	// Byte framer.
	//////////////////////////////////////////////////////////////////////

	localparam int CW = $clog2(BIT_CLKS + 1); // Bit timer width.

	mslc_state_t          state_reg;      // Framer state.
	mslc_state_t          state_next;     // Next framer state.
	logic [10:0]          frame_reg;      // Frame shift register, LSB goes first.
	logic [10:0]          frame_next;     // Next frame contents.
	logic [3:0]           bitcnt_reg;     // Bits left in the frame.
	logic [3:0]           bitcnt_next;    // Next bits-left count.
	logic [CW-1:0]        tmr_reg;        // Clocks left in current bit.
	logic [CW-1:0]        tmr_next;       // Next timer value.
	logic                 line_reg;       // Registered line level.
	logic                 line_next;      // Next line level.

	// Build the eleven-bit frame for one byte.
	function automatic logic [10:0] mslc_frame(input logic [7:0] d);
		logic par;
		par = (^d) ^ MSLC_PARITY_ODD;
		return {MSLC_STOP_LEVEL, par, d, MSLC_START_LEVEL};
	endfunction

	// A byte is accepted only when idle and the supply is in range.
	assign tx_ready = (state_reg == MSLC_IDLE) && supply_ok && !wd_pulse;

	// Next-state logic for the framer.
	always_comb begin
		state_next  = state_reg;
		frame_next  = frame_reg;
		bitcnt_next = bitcnt_reg;
		tmr_next    = tmr_reg;
		line_next   = line_reg;
		if (wd_pulse) begin
			// Restart drops any frame in flight and returns to idle.
			state_next  = MSLC_IDLE;
			line_next   = MSLC_IDLE_LEVEL;
			bitcnt_next = 4'd0;
			tmr_next    = '0;
		end else if (!supply_ok) begin
			// Out-of-range supply aborts the frame; the line stays idle.
			state_next  = MSLC_IDLE;
			line_next   = MSLC_IDLE_LEVEL;
			bitcnt_next = 4'd0;
			tmr_next    = '0;
		end else begin
			case (state_reg)
				MSLC_IDLE: begin
					line_next = MSLC_IDLE_LEVEL;
					if (tx_valid) begin
						frame_next  = mslc_frame(tx_data) >> 1;
						line_next   = MSLC_START_LEVEL;
						bitcnt_next = 4'(MSLC_FRAME_BITS - 1);
						tmr_next    = CW'(BIT_CLKS - 1);
						state_next  = MSLC_SHIFT;
					end
				end
				MSLC_SHIFT: begin
					if (tmr_reg != '0) begin
						tmr_next = tmr_reg - 1'b1;
					end else if (bitcnt_reg != 4'd0) begin
						// Next bit in D0-first order.
						line_next   = frame_reg[0];
						frame_next  = frame_reg >> 1;
						bitcnt_next = bitcnt_reg - 4'd1;
						tmr_next    = CW'(BIT_CLKS - 1);
					end else begin
						line_next  = MSLC_IDLE_LEVEL;
						state_next = MSLC_IDLE;
					end
				end
				default: begin
					state_next = MSLC_IDLE;
				end
			endcase
		end
	end

	// Register the framer state.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg  <= MSLC_IDLE;
			frame_reg  <= 11'h7ff;
			bitcnt_reg <= 4'h0;
			tmr_reg    <= '0;
			line_reg   <= 1'b1;
		end else begin
			state_reg  <= state_next;
			frame_reg  <= frame_next;
			bitcnt_reg <= bitcnt_next;
			tmr_reg    <= tmr_next;
			line_reg   <= line_next;
		end
	end

	// Gate the registered level so a supply drop silences the line at once.
	assign txd_out = supply_ok ? line_reg : MSLC_IDLE_LEVEL;

	//////////////////////////////////////////////////////////////////////
	// Checks.
	//////////////////////////////////////////////////////////////////////

	property p_flag_bit7;
		@(posedge core_clk) disable iff (sys_rst)
		1'b1 |=> motion_flags_byte[7] == $past(dir_info_avail);
	endproperty
	a_flag_bit7: assert property (p_flag_bit7) else $error("flags bit 7 wrong");

	property p_key_xor;
		@(posedge core_clk) disable iff (sys_rst)
		init_active |-> ((ident_key ^ master_key) == MSLC_KEY_CTRL_VECTOR);
	endproperty
	a_key_xor: assert property (p_key_xor) else $error("ident key wrong");

	property p_supply_gate;
		@(posedge core_clk) disable iff (sys_rst)
		!supply_ok |-> (txd_out == 1'b1 && !tx_ready);
	endproperty
	a_supply_gate: assert property (p_supply_gate) else $error("tx while supply bad");

	property p_wd_restart;
		@(posedge core_clk) disable iff (sys_rst)
		wd_pulse |=> (state_reg == MSLC_IDLE && txd_out == 1'b1);
	endproperty
	a_wd_restart: assert property (p_wd_restart) else $error("no restart on watchdog");

	property p_start_low;
		@(posedge core_clk) disable iff (sys_rst)
		(tx_valid && tx_ready) |=> (txd_out == 1'b0) || !supply_ok;
	endproperty
	a_start_low: assert property (p_start_low) else $error("start bit not low");

	property p_stop_high;
		@(posedge core_clk) disable iff (sys_rst)
		(state_reg == MSLC_SHIFT && bitcnt_reg == 4'd0) |-> txd_out == 1'b1;
	endproperty
	a_stop_high: assert property (p_stop_high) else $error("stop bit not high");

	property p_d0_first;
		@(posedge core_clk) disable iff (sys_rst)
		(tx_valid && tx_ready) |=> (state_reg == MSLC_SHIFT) && (frame_reg[7:0] == $past(tx_data));
	endproperty
	a_d0_first: assert property (p_d0_first) else $error("frame not started");

	property p_key_hidden;
		@(posedge core_clk) disable iff (sys_rst)
		!init_active |-> ident_key == '0;
	endproperty
	a_key_hidden: assert property (p_key_hidden) else $error("key visible outside init");
endmodule

// ---- testbench/mslc_vu_model.sv ----
// Vehicle unit model: frame receiver on the sensor line and watchdog pulser.
module mslc_vu_model
	import mslc_pkg::*;
#(
	parameter int BIT_CLKS = 4
)
(
	input  wire logic  core_clk,
	input  wire logic  sys_rst,
	input  wire logic  txd_in,
	input  wire logic  wd_fire,
	output logic       watchdog_in,
	output logic       rx_busy,
	output logic [10:0] rx_frame,
	output logic [7:0] rx_count
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt;     // Clocks counted since the start edge.
	int wd_left; // Cycles of watchdog pulse still to drive.
	// This model keeps no key material at all.
	// Slot k is sampled mid-bit: 0 start, 1..8 D0..D7, 9 parity, 10 stop.
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_busy <= 1'b0;
			rx_count <= 8'h00;
			rx_frame <= 11'h7ff;
			watchdog_in <= 1'b0;
			cnt = 0;
			wd_left = 0;
		end else begin
			watchdog_in <= (wd_left > 0);
			if (wd_left > 0)
				wd_left = wd_left - 1;
			if (wd_fire) begin // A timed-out reply is answered by a pulse, not a retry.
				wd_left = 3;
				rx_busy <= 1'b0;
				cnt = 0;
			end else if (!rx_busy && !txd_in && wd_left == 0 && !watchdog_in) begin // Low opens a frame.
				rx_busy <= 1'b1;
				cnt = 1;
			end else if (rx_busy) begin
				cnt = cnt + 1;
			end
			if (cnt > 0 && cnt % BIT_CLKS == BIT_CLKS / 2)
				rx_frame[cnt / BIT_CLKS] <= txd_in;
			if (cnt == 11 * BIT_CLKS) begin
				rx_busy <= 1'b0;
				rx_count <= rx_count + 8'h01;
				cnt = 0;
			end
		end
	end
endmodule

// ---- testbench/motion_sensor_link_core_bench.sv ----
// Self-checking bench for the motion sensor link core.
module motion_sensor_link_core_bench
	import mslc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int B = 4; // Short bit period keeps the run brief.
	logic core_clk = 0, sys_rst = 1, supply_ok = 1, tx_valid = 0, dir_info_avail = 0, init_active = 0, wd_fire = 0;
	logic [7:0] tx_data = 0, motion_flags_byte, rx_count;
	logic [6:0] motion_flags_low = 0;
	logic [127:0] master_key = 0, ident_key;
	logic watchdog_in, tx_ready, txd_out, rx_busy;
	logic [10:0] rx_frame;
	int n_fail = 0, n_compared = 0;
	logic [7:0] vals [5] = '{8'h01, 8'h80, 8'ha5, 8'hff, 8'h00};
	mslc_core #(.BIT_CLKS(B)) DUT (.core_clk, .sys_rst, .watchdog_in, .supply_ok, .tx_valid, .tx_data,
		.tx_ready, .txd_out, .motion_flags_low, .dir_info_avail, .motion_flags_byte, .master_key,
		.init_active, .ident_key);
	mslc_vu_model #(.BIT_CLKS(B)) vu (.core_clk, .sys_rst, .txd_in(txd_out), .wd_fire, .watchdog_in,
		.rx_busy, .rx_frame, .rx_count);
	initial forever #12.5 core_clk = ~core_clk;
	//////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("Compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cmp(input logic [127:0] got, input logic [127:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic give_up();
		n_fail++;
		$display("MISMATCH at %0t: wait ran out", $time);
		final_report();
	endtask
	// Waits until the receiver is quiet and the sensor will take a byte.
	task automatic wait_idle();
		int i;
		for (i = 0; i < 100 * B && (rx_busy !== 1'b0 || tx_ready !== 1'b1); i++)
			@(negedge core_clk);
		if (i == 100 * B)
			give_up();
	endtask
	// Offers a byte and returns at the falling edge after it was taken.
	task automatic send(input logic [7:0] d);
		int i;
		tx_data = d;
		tx_valid = 1'b1;
		for (i = 0; i < 50 && tx_ready !== 1'b1; i++)
			@(negedge core_clk);
		if (i == 50)
			give_up();
		@(negedge core_clk);
		tx_valid = 1'b0;
	endtask
	task automatic byte_check(input logic [7:0] d);
		logic [7:0] c;
		c = rx_count;
		send(d);
		wait_idle();
		cmp(rx_count, c + 8'h01, "frames");
		cmp(rx_frame, {1'b1, ^d, d, 1'b0}, "frame");
	endtask
	//////////////////////////////////////////////////////////////////
	task automatic flags_and_key();
		motion_flags_low = 7'h2a;
		dir_info_avail = 1'b1;
		repeat (2) @(negedge core_clk);
		cmp(motion_flags_byte, 8'haa, "flags set");
		motion_flags_low = 7'h7f;
		dir_info_avail = 1'b0;
		repeat (2) @(negedge core_clk);
		cmp(motion_flags_byte, 8'h7f, "flags clear");
		master_key = 128'h0123456789abcdeffedcba9876543210;
		init_active = 1'b1;
		// Hold initialisation across a clock edge so the key check in the design also runs.
		@(negedge core_clk);
		cmp(ident_key, master_key ^ 128'h48215f000341328a00684d00cb21701d, "key");
		init_active = 1'b0;
		#1 cmp(ident_key, 128'h0, "key hidden");
		@(negedge core_clk);
	endtask
	// The supply drops in mid-frame while a byte is offered.
	task automatic supply_drop();
		send(8'h00);
		repeat (3 * B) @(negedge core_clk);
		supply_ok = 1'b0;
		tx_valid = 1'b1;
		#1 cmp(txd_out, 1'b1, "gated line");
		cmp(tx_ready, 1'b0, "ready gated");
		repeat (12 * B) @(negedge core_clk);
		cmp(txd_out, 1'b1, "still gated");
		cmp(tx_ready, 1'b0, "ready held off while idle");
		tx_valid = 1'b0;
		supply_ok = 1'b1;
		wait_idle();
		cmp(txd_out, 1'b1, "idle after supply");
	endtask
	// A watchdog pulse in mid-frame must abandon the byte.
	task automatic watchdog_restart();
		logic [7:0] c;
		send(8'h00);
		repeat (2 * B) @(negedge core_clk);
		c = rx_count;
		wd_fire = 1'b1;
		@(negedge core_clk);
		wd_fire = 1'b0;
		repeat (5) @(negedge core_clk);
		wait_idle();
		repeat (12 * B) @(negedge core_clk);
		cmp(rx_busy, 1'b0, "no frame after pulse");
		cmp(rx_count, c, "aborted");
		byte_check(8'h5a);
	endtask
	initial begin
		repeat (20) @(negedge core_clk);
		cmp(txd_out, 1'b1, "reset line");
		cmp(motion_flags_byte, 8'h00, "reset flags");
		sys_rst = 1'b0;
		foreach (vals[i])
			byte_check(vals[i]);
		flags_and_key();
		supply_drop();
		watchdog_restart();
		final_report();
	end
endmodule
